// File: src/rtccv_top.sv
// Configuration register and time value window of the real-time clock
// Behaviour
// - Output enable bit 10 gates timekeeper output
// - Pointer selects byte pair in value window
// - High byte access decrements pointer, floor 00
// - Configuration register cleared only at power-on
// - Enable bit writable only when unlocked
// - Half-second flag read-only, cleared by seconds write
// - Second register: eight upper bits, lower zero
// - Window writes accepted only when unlocked
// - Half-second flag high in second half
// - Reading either window byte decrements pointer
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtccv_defs.svh"
module rtccv_top
  import rtccv_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = (`RTCCV_SECOND_NS / `RTCCV_CLK_NS) / 2
) (
  // Clock and power-on reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  byte_en,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  // Timekeeper output and status
  output logic             timekeeper_out,
  output logic             timekeeper_out_en,
  output logic             module_enable,
  output logic      [7:0]  power_ctl_bits
);
  rtccv_bus_t  bus;
  rtccv_time_t time_reg;
  logic [15:0] calcfg_reg;
  logic [7:0]  pwc_reg;
  logic [7:0]  cal_reg;
  logic        half_second_flag;
  logic        second_tick;
  logic        win_access;
  logic        win_hi_wr;
  logic        win_lo_wr;
  logic        minutes_seconds_pair_lo_wr;
  logic        cal_wr;
  logic [1:0]  value_window_pointer;
  logic [15:0] window_word;
  logic [15:0] rdata_next;

  assign bus = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
  assign cal_wr = bus.wr && bus.addr == `RTCCV_OFF_CALCFG;
  assign value_window_pointer = calcfg_reg[`RTCCV_PTR_HI:`RTCCV_PTR_LO];
  assign module_enable = calcfg_reg[`RTCCV_BIT_ENABLE];

  // Window accesses: any read, or a high-byte write
  assign win_access = bus.addr == `RTCCV_OFF_VALUE &&
                      (bus.rd || (bus.wr && byte_en[1]));
  assign win_hi_wr = bus.wr && bus.addr == `RTCCV_OFF_VALUE && byte_en[1] &&
                     calcfg_reg[`RTCCV_BIT_UNLOCK];
  assign win_lo_wr = bus.wr && bus.addr == `RTCCV_OFF_VALUE && byte_en[0] &&
                     calcfg_reg[`RTCCV_BIT_UNLOCK];
  assign minutes_seconds_pair_lo_wr = (win_lo_wr && value_window_pointer == RTCCV_SEL_MINUTES_SECONDS_PAIR) ||
                        (bus.wr && bus.addr == `RTCCV_OFF_MINUTES_SECONDS_PAIR_LO &&
                         calcfg_reg[`RTCCV_BIT_UNLOCK]);

  // Configuration register; the only reset is power-on
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      calcfg_reg <= `RTCCV_CALCFG_RST;
    end else begin
      if (cal_wr) begin
        if (calcfg_reg[`RTCCV_BIT_UNLOCK]) begin
          calcfg_reg[`RTCCV_BIT_ENABLE] <= bus.wdata[`RTCCV_BIT_ENABLE];
        end
        calcfg_reg[`RTCCV_BIT_UNLOCK] <= bus.wdata[`RTCCV_BIT_UNLOCK];
        calcfg_reg[`RTCCV_BIT_OUTEN]  <= bus.wdata[`RTCCV_BIT_OUTEN];
        calcfg_reg[`RTCCV_PTR_HI:`RTCCV_PTR_LO] <=
          bus.wdata[`RTCCV_PTR_HI:`RTCCV_PTR_LO];
        calcfg_reg[7:0] <= bus.wdata[7:0];
      end else if (win_access && value_window_pointer != `RTCCV_PTR_FLOOR) begin
        calcfg_reg[`RTCCV_PTR_HI:`RTCCV_PTR_LO] <=
          value_window_pointer - 2'b01;
      end
      calcfg_reg[14] <= 1'b0;
      calcfg_reg[`RTCCV_BIT_SYNC] <= 1'b0;
      calcfg_reg[`RTCCV_BIT_HALF_SECOND_FLAG] <= half_second_flag;
    end
  end

  assign cal_reg = calcfg_reg[7:0];

  // Second configuration register, upper byte only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pwc_reg <= `RTCCV_PWCCFG_RST;
    end else if (bus.wr && bus.addr == `RTCCV_OFF_PWCCFG) begin
      pwc_reg <= bus.wdata[15:8];
    end
  end
  assign power_ctl_bits = pwc_reg;

  // Half-second phase; cleared by a write to the seconds byte
  rtccv_half_sec #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_half (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .run              (module_enable),
    .clear            (minutes_seconds_pair_lo_wr),
    .half_second_flag (half_second_flag),
    .second_tick      (second_tick)
  );

  // Time value storage, one byte pair per pointer value except 11, which holds the year byte only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      time_reg <= '0;
    end else begin
      if (win_hi_wr) begin
        case (value_window_pointer)
          RTCCV_SEL_MINUTES_SECONDS_PAIR: time_reg.minutes <= bus.wdata[15:8];
          RTCCV_SEL_WDHR:   time_reg.weekday <= bus.wdata[15:8];
          RTCCV_SEL_MTHDAY: time_reg.month   <= bus.wdata[15:8];
          default:          ;
        endcase
      end
      if (win_lo_wr) begin
        case (value_window_pointer)
          RTCCV_SEL_MINUTES_SECONDS_PAIR: time_reg.seconds <= bus.wdata[7:0];
          RTCCV_SEL_WDHR:   time_reg.hours   <= bus.wdata[7:0];
          RTCCV_SEL_MTHDAY: time_reg.day     <= bus.wdata[7:0];
          default:          time_reg.year    <= bus.wdata[7:0];
        endcase
      end else if (bus.wr && bus.addr == `RTCCV_OFF_MINUTES_SECONDS_PAIR_LO &&
                   calcfg_reg[`RTCCV_BIT_UNLOCK]) begin
        time_reg.seconds <= bus.wdata[7:0];
      end else if (second_tick && !win_hi_wr) begin
        time_reg.seconds <= (time_reg.seconds == 8'h3b) ? 8'h00 :
                            time_reg.seconds + 8'h01;
      end
    end
  end

  // Byte pair chosen by the pointer
  always_comb begin
    case (value_window_pointer)
      RTCCV_SEL_MINUTES_SECONDS_PAIR: window_word = {time_reg.minutes, time_reg.seconds};
      RTCCV_SEL_WDHR:   window_word = {time_reg.weekday, time_reg.hours};
      RTCCV_SEL_MTHDAY: window_word = {time_reg.month, time_reg.day};
      default:          window_word = {8'h00, time_reg.year};
    endcase
  end

  // Read mux
  always_comb begin
    case (bus.addr)
      `RTCCV_OFF_CALCFG:    rdata_next = calcfg_reg;
      `RTCCV_OFF_PWCCFG:    rdata_next = {pwc_reg, 8'h00};
      `RTCCV_OFF_VALUE:     rdata_next = window_word;
      `RTCCV_OFF_MINUTES_SECONDS_PAIR_LO: rdata_next = {8'h00, time_reg.seconds};
      default:              rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Timekeeper output: half-second square wave
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      timekeeper_out    <= 1'b0;
      timekeeper_out_en <= 1'b0;
    end else begin
      timekeeper_out_en <= calcfg_reg[`RTCCV_BIT_OUTEN];
      timekeeper_out    <= calcfg_reg[`RTCCV_BIT_OUTEN] & half_second_flag;
    end
  end

  logic unused_cal;
  assign unused_cal = ^cal_reg;
endmodule
`default_nettype wire

// File: src/rtccv_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RTCCV_DEFS_SVH
`define RTCCV_DEFS_SVH

// Register word offsets
`define RTCCV_OFF_CALCFG    4'h0
`define RTCCV_OFF_PWCCFG    4'h1
`define RTCCV_OFF_VALUE     4'h2
`define RTCCV_OFF_MINUTES_SECONDS_PAIR_LO 4'h3

// Calibration and configuration fields
`define RTCCV_BIT_ENABLE    15
`define RTCCV_BIT_UNLOCK    13
`define RTCCV_BIT_SYNC      12
`define RTCCV_BIT_HALF_SECOND_FLAG   11
`define RTCCV_BIT_OUTEN     10
`define RTCCV_PTR_HI        9
`define RTCCV_PTR_LO        8

// Reset values and pointer floor
`define RTCCV_CALCFG_RST    16'h0000
`define RTCCV_PWCCFG_RST    8'h00
`define RTCCV_PTR_FLOOR     2'b00

// Timing: one second at the system clock
`define RTCCV_SECOND_NS     1000000000
`define RTCCV_CLK_NS        100

`endif

// File: src/rtccv_pkg.sv
// Types shared by the configuration and value window logic
package rtccv_pkg;

  typedef enum logic [1:0] {
    RTCCV_SEL_MINUTES_SECONDS_PAIR  = 2'b00,
    RTCCV_SEL_WDHR    = 2'b01,
    RTCCV_SEL_MTHDAY  = 2'b10,
    RTCCV_SEL_RSVYEAR = 2'b11
  } rtccv_sel_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } rtccv_bus_t;

  typedef struct packed {
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] weekday;
    logic [7:0] hours;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] year;
  } rtccv_time_t;

endpackage

// File: src/rtccv_half_sec.sv
// Half-second phase generator with software clear
`timescale 1ns/1ps
`default_nettype none
`include "rtccv_defs.svh"
module rtccv_half_sec #(
  parameter int unsigned HALF_CYCLES = (`RTCCV_SECOND_NS / `RTCCV_CLK_NS) / 2
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Control
  input  wire logic run,
  input  wire logic clear,
  // Status
  output logic      half_second_flag,
  output logic      second_tick
);
  logic [31:0] count_reg;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_reg        <= 32'h0000_0000;
      half_second_flag <= 1'b0;
      second_tick      <= 1'b0;
    end else begin
      second_tick <= 1'b0;
      if (clear) begin
        // Restart the second at its first half
        count_reg        <= 32'h0000_0000;
        half_second_flag <= 1'b0;
      end else if (run) begin
        if (count_reg == HALF_CYCLES - 1) begin
          count_reg        <= 32'h0000_0000;
          half_second_flag <= ~half_second_flag;
          second_tick      <= half_second_flag;
        end else begin
          count_reg <= count_reg + 32'h0000_0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/rtccv_top_assertions.sv
// Port checks for the configuration and value window block
`timescale 1ns/1ps
`default_nettype none
module rtccv_top_check #(
  parameter int unsigned HALF_CYCLES = 4
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0]  byte_en,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  // Outputs
  input wire logic        timekeeper_out,
  input wire logic        timekeeper_out_en,
  input wire logic        module_enable,
  input wire logic [7:0]  power_ctl_bits
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (!rd_stb |=> rdata == 16'h0000) else $error("rdata not idle");
  a_enable_cause: assert property ($changed(module_enable) |-> $past(wr_stb) &&
    $past(addr) == 4'h0) else $error("enable changed without write");
  a_pwc_hold: assert property ($changed(power_ctl_bits) |-> $past(wr_stb) &&
    $past(addr) == 4'h1) else $error("power bits changed without write");
  a_pwc_load: assert property (wr_stb && addr == 4'h1 && byte_en[1] |=>
    power_ctl_bits == $past(wdata[15:8])) else $error("power bits not loaded");
  a_pwc_low: assert property (rd_stb && addr == 4'h1 |=> rdata[7:0] == 8'h00)
    else $error("power low byte not zero");
  a_unmapped_zero: assert property (rd_stb && addr > 4'h3 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_cfg_enable: assert property (rd_stb && addr == 4'h0 |=>
    rdata[15] == module_enable && !rdata[14]) else $error("enable bit readback");
  a_out_gated: assert property (timekeeper_out |->
    timekeeper_out_en || $past(timekeeper_out_en)) else $error("output without enable");
  a_outen_set: assert property (wr_stb && addr == 4'h0 && byte_en[1] && wdata[10] |->
    ##[1:2] timekeeper_out_en) else $error("output enable not set");
endmodule
bind rtccv_top rtccv_top_check #(.HALF_CYCLES(HALF_CYCLES)) i_check (.sys_clk(sys_clk),
  .reset(reset), .addr(addr), .wdata(wdata), .byte_en(byte_en), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .timekeeper_out(timekeeper_out),
  .timekeeper_out_en(timekeeper_out_en), .module_enable(module_enable),
  .power_ctl_bits(power_ctl_bits));
`default_nettype wire

// File: bench/rtc_config_value_window_test.sv
// Self-checking bench for the configuration and value window block
`timescale 1ns/1ps
`default_nettype none
module rtc_config_value_window_test;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [1:0]  byte_en = 2'b00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        rd_q = 1'b0;
  logic [15:0] rdata;
  logic        tk_out;
  logic        tk_en;
  logic        mod_en;
  logic [7:0]  pwc;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  logic [15:0] v[4];
  logic [7:0]  cal;
  int          bad_count = 0;
  int          compares = 0;
  int          seed = 41;
  rtccv_top #(.HALF_CYCLES(4)) i_dut (.sys_clk(sys_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .byte_en(byte_en), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .timekeeper_out(tk_out), .timekeeper_out_en(tk_en), .module_enable(mod_en),
    .power_ctl_bits(pwc));
  always #50 sys_clk = ~sys_clk;
  task check(input string n, input logic [15:0] ex, input logic [15:0] got);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, ex, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    byte_en <= 2'b11;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] ex, input logic [15:0] m);
    exp_q.push_back({m, ex & m});
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task idle(input int n);
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  task count_out(input logic [4:0] ex);
    logic [4:0] n;
    n = 5'h0;
    idle(3);
    repeat (16) begin
      @(posedge sys_clk);
      n = n + 5'(tk_out);
    end
    check("timekeeper_out highs", 16'(ex), 16'(n));
  endtask
  task final_report;
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Read results land one cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      check("rdata", e[15:0], rdata & e[31:16]);
    end
    rd_q <= rd_stb;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    bad_count++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(4'h0, 16'h0000, 16'hFFFF);
    rd(4'h1, 16'h0000, 16'hFFFF);
    rd(4'h9, 16'h0000, 16'hFFFF);
    wr(4'h0, 16'h8000);
    rd(4'h0, 16'h0000, 16'hE7FF);
    wr(4'h0, 16'h0300);
    wr(4'h2, 16'h1234);
    rd(4'h0, 16'h0200, 16'h0300);
    cal = 8'($random(seed));
    wr(4'h0, 16'h2000);
    wr(4'h0, {8'hA7, cal});
    rd(4'h0, {8'hA7, cal}, 16'hE7FF);
    check("module_enable", 16'h0001, 16'(mod_en));
    for (int p = 3; p >= 0; p--) begin
      v[p] = 16'($random(seed));
      if (p == 0) v[p][7:0] = 8'h00;
      wr(4'h2, v[p]);
    end
    v[3][15:8] = 8'h00;
    wr(4'h0, {8'hA7, cal});
    for (int p = 3; p >= 0; p--) rd(4'h2, v[p], p == 0 ? 16'hFF00 : 16'hFFFF);
    rd(4'h2, v[0], 16'hFF00);
    rd(4'h0, 16'h0000, 16'h0300);
    wr(4'h3, 16'h0000);
    idle(1);
    rd(4'h0, 16'h0000, 16'h0800);
    count_out(5'd8);
    check("timekeeper_out_en", 16'h0001, 16'(tk_en));
    wr(4'h0, {8'h83, cal});
    wr(4'h2, ~v[2]);
    rd(4'h2, v[2], 16'hFFFF);
    count_out(5'd0);
    check("timekeeper_out_en", 16'h0000, 16'(tk_en));
    v[1] = 16'($random(seed));
    wr(4'h1, v[1]);
    rd(4'h1, {v[1][15:8], 8'h00}, 16'hFFFF);
    check("power_ctl_bits", 16'(v[1][15:8]), 16'(pwc));
    idle(2);
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    rd(4'h0, 16'h0000, 16'hFFFF);
    rd(4'h1, 16'h0000, 16'hFFFF);
    idle(3);
    check("module_enable", 16'h0000, 16'(mod_en));
    check("power_ctl_bits", 16'h0000, 16'(pwc));
    check("timekeeper_out", 16'h0000, 16'(tk_out));
    final_report;
  end
endmodule
`default_nettype wire
